// file: rtl/ecpph_pkg.sv
// shared constants and types for the parallel handshake block
package ecpph_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 25;
   localparam int SETUP_NS = 100;
   localparam int FIFO_STB_NS = 500;
   localparam int WAIT_SETTLE_NS = 50;
   localparam int CNT_W = 5;
   typedef logic [CNT_W-1:0] ecpph_cnt_t;
   localparam ecpph_cnt_t SETUP_CYC =
      CNT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam ecpph_cnt_t FIFO_STB_CYC =
      CNT_W'((FIFO_STB_NS + CLK_NS - 1) / CLK_NS);
   localparam int SETTLE_CYC = (WAIT_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam ecpph_cnt_t CNT_ONE = CNT_W'(1);

   // ----------------------------------------------------------------
   // data path
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 8;
   typedef logic [DATA_W-1:0] ecpph_data_t;

   // ----------------------------------------------------------------
   // pin levels and reset values
   // ----------------------------------------------------------------
   localparam logic HOST_CLK_IDLE = 1'b1;
   localparam logic HOST_ACK_FWD = 1'b1;
   localparam logic HOST_ACK_REV = 1'b0;
   localparam logic WRITE_N_IDLE = 1'b1;
   localparam logic IN_HIGH_RST = 1'b1;
   localparam logic IN_LOW_RST = 1'b0;

   typedef enum logic [2:0] {
      ST_FWD_IDLE,
      ST_FWD_SETUP,
      ST_FWD_STB,
      ST_FWD_REL,
      ST_REV_IDLE,
      ST_REV_ACK
   } ecpph_state_e;

endpackage

// file: rtl/ecpph_fifo_if.sv
// carrier between the handshake core and its transmit fifo
`timescale 1ns/100ps
interface ecpph_fifo_if #(
   parameter int W = 8
);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;

   modport fifo (
      input wr_valid, wr_data, rd_ready,
      output wr_ready, rd_valid, rd_data
   );
   modport user (
      output wr_valid, wr_data, rd_ready,
      input wr_ready, rd_valid, rd_data
   );
endinterface

// file: rtl/ecpph_sync.sv
// two-flop synchroniser with a stable-time filter
`timescale 1ns/100ps
module ecpph_sync #(
   parameter int STABLE = 1,
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic d_i,
   output logic q_o
);
   import ecpph_pkg::*;

   localparam logic [3:0] LAST = 4'(STABLE - 1);

   logic s1_q, s2_q, q_q, q_d;
   logic [3:0] cnt_q, cnt_d;

   // ----------------------------------------------------------------
   // stable counter
   // ----------------------------------------------------------------
   always_comb begin
      q_d = q_q;
      cnt_d = '0;
      if (s2_q != q_q) begin
         if (cnt_q >= LAST) begin
            q_d = s2_q;
         end else begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         q_q <= RST_VAL;
         cnt_q <= '0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         q_q <= q_d;
         cnt_q <= cnt_d;
      end
   end

   assign q_o = q_q;

   AST_SETTLED_ONLY_AFTER_STABLE: assert property (
      @(posedge clk) disable iff (reset)
      $changed(q_q) |-> $past(cnt_q) == LAST && $past(s2_q) == q_q)
      else $error("filtered level changed before it was stable");

endmodule // ecpph_sync

// file: rtl/ecpph_fifo.sv
// transmit fifo between the user port and the forward handshake
`timescale 1ns/100ps
module ecpph_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   ecpph_fifo_if.fifo f
);
   import ecpph_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic nfull_q, nfull_d, nempty_q, nempty_d;
   logic push, pop;

   // ----------------------------------------------------------------
   // pointers and flags
   // ----------------------------------------------------------------
   always_comb begin
      push = f.wr_valid & nfull_q;
      pop = f.rd_ready & nempty_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      nfull_d = (cnt_d != FULL);
      nempty_d = (cnt_d != '0);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         nfull_q <= 1'b1;
         nempty_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         nfull_q <= nfull_d;
         nempty_q <= nempty_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= f.wr_data;
      end
   end

   assign f.wr_ready = nfull_q;
   assign f.rd_valid = nempty_q;
   assign f.rd_data = mem[rd_q];

endmodule // ecpph_fifo

// file: rtl/ecpph_top.sv
// host side handshake of a multi-mode parallel port
//
// Summary of operation
// - in fifo mode forward strobes are timed and nAck is ignored, the next byte waiting only on Busy low.
// - in forward idle HostClk stays high while the peripheral keeps Busy low.
// - forward transfers start only from forward idle, and a reversal request on nFault is caught in any forward state, not in reverse idle or ack.
// - a transfer starts only with Busy low, and data is driven for the setup time before HostClk falls.
// - HostClk returns high after Busy rises except in fifo mode, and the transfer ends when Busy falls again.
// - in reverse idle the host holds HostAck low while the peripheral holds PeriphClk high.
// - a reverse transfer starts only from reverse idle, HostAck low meaning the previous byte is taken.
// - the host raises HostAck when ready, waits PeriphClk high, then lowers HostAck with the byte taken.
// - HostClk and HostAck are push-pull in ECP mode, open-collector otherwise, switched only at idle.
// - nWAIT counts as settled only after it has not changed for 50 ns.
// - nWRITE stays high whenever no EPP write cycle runs.
`timescale 1ns/100ps
module ecpph_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic ecp_mode_i,
   input wire logic fifo_mode_i,
   input wire logic epp_mode_i,
   input wire logic epp_wr_i,
   input wire logic rev_en_i,
   input wire logic fwd_req_i,
   input wire logic tx_valid_i,
   input wire ecpph_pkg::ecpph_data_t tx_data_i,
   output logic tx_ready_o,
   output ecpph_pkg::ecpph_data_t rx_data_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   input wire ecpph_pkg::ecpph_data_t pd_i,
   output ecpph_pkg::ecpph_data_t pd_o,
   output logic pd_oe,
   output logic host_clk_o,
   output logic host_clk_oe,
   output logic host_ack_o,
   output logic host_ack_oe,
   input wire logic periph_ack_i,
   input wire logic periph_clk_i,
   input wire logic periph_req_n_i,
   input wire logic wait_n_i,
   output logic wait_n_settled_o,
   output logic write_n_o,
   output logic rev_o
);
   import ecpph_pkg::*;

   ecpph_state_e st_q, st_d;
   ecpph_cnt_t cnt_q, cnt_d;
   ecpph_data_t pd_q, pd_d, rx_data_q, rx_data_d;
   ecpph_data_t pd_s1_q, pd_s2_q;
   logic pd_oe_q, pd_oe_d;
   logic hclk_q, hclk_d, hack_q, hack_d;
   logic hclk_oe_q, hclk_oe_d, hack_oe_q, hack_oe_d;
   logic ecp_q, ecp_d, fifo_q, fifo_d;
   logic rx_valid_q, rx_valid_d;
   logic pend_q, pend_d;
   logic write_n_q, write_n_d;
   logic rev_q, rev_d;
   logic busy_s, pclk_s, req_n_s;
   logic pop;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   ecpph_sync #(.STABLE(1), .RST_VAL(IN_LOW_RST)) u_busy (
      .clk(clk),
      .reset(reset),
      .d_i(periph_ack_i),
      .q_o(busy_s)
   );

   ecpph_sync #(.STABLE(1), .RST_VAL(IN_HIGH_RST)) u_pclk (
      .clk(clk),
      .reset(reset),
      .d_i(periph_clk_i),
      .q_o(pclk_s)
   );

   ecpph_sync #(.STABLE(1), .RST_VAL(IN_HIGH_RST)) u_req (
      .clk(clk),
      .reset(reset),
      .d_i(periph_req_n_i),
      .q_o(req_n_s)
   );

   ecpph_sync #(.STABLE(SETTLE_CYC), .RST_VAL(IN_HIGH_RST)) u_wait (
      .clk(clk),
      .reset(reset),
      .d_i(wait_n_i),
      .q_o(wait_n_settled_o)
   );

   // ----------------------------------------------------------------
   // transmit fifo
   // ----------------------------------------------------------------
   ecpph_fifo_if #(.W(DATA_W)) tx_if ();

   assign tx_if.wr_valid = tx_valid_i;
   assign tx_if.wr_data = tx_data_i;
   assign tx_if.rd_ready = pop;
   assign tx_ready_o = tx_if.wr_ready;

   ecpph_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .f(tx_if.fifo)
   );

   // ----------------------------------------------------------------
   // handshake state machine
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      pd_d = pd_q;
      pd_oe_d = pd_oe_q;
      hclk_d = hclk_q;
      hack_d = hack_q;
      ecp_d = ecp_q;
      fifo_d = fifo_q;
      rx_data_d = rx_data_q;
      rx_valid_d = 1'b0;
      pend_d = pend_q;
      pop = 1'b0;
      case (st_q)
         ST_FWD_IDLE: begin
            hclk_d = HOST_CLK_IDLE;
            hack_d = HOST_ACK_FWD;
            ecp_d = ecp_mode_i;
            fifo_d = fifo_mode_i;
            if (pend_q && rev_en_i) begin
               st_d = ST_REV_IDLE;
               pd_oe_d = 1'b0;
               hack_d = HOST_ACK_REV;
               pend_d = 1'b0;
            end else if (tx_if.rd_valid && !busy_s) begin
               st_d = ST_FWD_SETUP;
               pd_d = tx_if.rd_data;
               pd_oe_d = 1'b1;
               pop = 1'b1;
               cnt_d = SETUP_CYC;
            end
         end
         ST_FWD_SETUP: begin
            if (cnt_q <= CNT_ONE) begin
               hclk_d = ~HOST_CLK_IDLE;
               cnt_d = FIFO_STB_CYC;
               st_d = ST_FWD_STB;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         ST_FWD_STB: begin
            if (fifo_q) begin
               if (cnt_q <= CNT_ONE) begin
                  hclk_d = HOST_CLK_IDLE;
                  st_d = ST_FWD_REL;
               end else begin
                  cnt_d = cnt_q - CNT_ONE;
               end
            end else if (busy_s) begin
               hclk_d = HOST_CLK_IDLE;
               st_d = ST_FWD_REL;
            end
         end
         ST_FWD_REL: begin
            if (!busy_s) begin
               st_d = ST_FWD_IDLE;
            end
         end
         ST_REV_IDLE: begin
            hack_d = HOST_ACK_REV;
            if (!pclk_s && rx_ready_i) begin
               hack_d = ~HOST_ACK_REV;
               rx_data_d = pd_s2_q;
               st_d = ST_REV_ACK;
            end else if (pclk_s && fwd_req_i) begin
               hack_d = HOST_ACK_FWD;
               st_d = ST_FWD_IDLE;
            end
         end
         ST_REV_ACK: begin
            if (pclk_s) begin
               hack_d = HOST_ACK_REV;
               rx_valid_d = 1'b1;
               st_d = ST_REV_IDLE;
            end
         end
         default: begin
            st_d = ST_FWD_IDLE;
         end
      endcase
      if (!req_n_s && st_d != ST_REV_IDLE && st_d != ST_REV_ACK) begin
         pend_d = 1'b1;
      end
      hclk_oe_d = ecp_d | ~hclk_d;
      hack_oe_d = ecp_d | ~hack_d;
      write_n_d = ~(epp_mode_i & epp_wr_i);
      rev_d = ~pd_oe_d;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= ST_FWD_IDLE;
         cnt_q <= '0;
         pd_q <= '0;
         pd_oe_q <= 1'b0;
         hclk_q <= HOST_CLK_IDLE;
         hack_q <= HOST_ACK_FWD;
         hclk_oe_q <= 1'b0;
         hack_oe_q <= 1'b0;
         ecp_q <= 1'b0;
         fifo_q <= 1'b0;
         rx_data_q <= '0;
         rx_valid_q <= 1'b0;
         pend_q <= 1'b0;
         write_n_q <= WRITE_N_IDLE;
         rev_q <= 1'b1;
         pd_s1_q <= '0;
         pd_s2_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         pd_q <= pd_d;
         pd_oe_q <= pd_oe_d;
         hclk_q <= hclk_d;
         hack_q <= hack_d;
         hclk_oe_q <= hclk_oe_d;
         hack_oe_q <= hack_oe_d;
         ecp_q <= ecp_d;
         fifo_q <= fifo_d;
         rx_data_q <= rx_data_d;
         rx_valid_q <= rx_valid_d;
         pend_q <= pend_d;
         write_n_q <= write_n_d;
         rev_q <= rev_d;
         pd_s1_q <= pd_i;
         pd_s2_q <= pd_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign pd_o = pd_q;
   assign pd_oe = pd_oe_q;
   assign host_clk_o = hclk_q;
   assign host_clk_oe = hclk_oe_q;
   assign host_ack_o = hack_q;
   assign host_ack_oe = hack_oe_q;
   assign rx_data_o = rx_data_q;
   assign rx_valid_o = rx_valid_q;
   assign write_n_o = write_n_q;
   assign rev_o = rev_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_FWD_IDLE_CLK_HIGH: assert property (
      st_q == ST_FWD_IDLE |-> hclk_q && hack_q == HOST_ACK_FWD)
      else $error("host clock low in forward idle");

   AST_FWD_FROM_IDLE: assert property (
      st_q == ST_FWD_SETUP && $past(st_q) != ST_FWD_SETUP
      |-> $past(st_q) == ST_FWD_IDLE && !$past(busy_s))
      else $error("forward transfer started outside idle");

   AST_SETUP_BEFORE_FALL: assert property (
      $fell(hclk_q) |-> pd_oe_q && $stable(pd_q)
      && $past(st_q) == ST_FWD_SETUP)
      else $error("host clock fell without data setup");

   AST_ECP_RISE_ON_BUSY: assert property (
      $rose(hclk_q) && !fifo_q |-> $past(busy_s))
      else $error("host clock rose before acknowledge");

   AST_FIFO_PULSE_TIMED: assert property (
      st_q == ST_FWD_STB && fifo_q && cnt_q == CNT_ONE
      |=> hclk_q && st_q == ST_FWD_REL)
      else $error("fifo mode strobe not released on time");

   AST_REV_IDLE_ACK_LOW: assert property (
      st_q == ST_REV_IDLE && $past(st_q) == ST_REV_IDLE
      |-> hack_q == HOST_ACK_REV && !pd_oe_q)
      else $error("host acknowledge high in reverse idle");

   AST_REV_FROM_IDLE: assert property (
      $rose(hack_q) && st_q != ST_FWD_IDLE |-> $past(st_q) == ST_REV_IDLE
      && !$past(pclk_s))
      else $error("reverse transfer entered outside idle");

   AST_REV_COMPLETE: assert property (
      $fell(hack_q) && $past(st_q) != ST_FWD_IDLE
      |-> st_q == ST_REV_IDLE && rx_valid_q && $past(pclk_s)
      && $past(st_q) == ST_REV_ACK)
      else $error("reverse byte not completed properly");

   AST_OPEN_COLLECTOR: assert property (
      !ecp_q |-> (hclk_oe_q == !hclk_q) && (hack_oe_q == !hack_q))
      else $error("compatible mode drives a control line high");

   AST_DRIVER_SWITCH_IDLE: assert property (
      $changed(ecp_q) |-> $past(st_q) == ST_FWD_IDLE && $past(hclk_q))
      else $error("driver type changed outside idle");

   AST_WRITE_N_HIGH: assert property (
      !(epp_mode_i && epp_wr_i) |=> write_n_q)
      else $error("write strobe low without a write cycle");

   AST_RESET_IDLE: assert property (
      $past(reset) |-> st_q == ST_FWD_IDLE && hclk_q)
      else $error("port not in forward idle after reset");

   COV_FWD_DONE: cover property (
      st_q == ST_FWD_REL ##1 st_q == ST_FWD_IDLE);

   COV_FIFO_MODE: cover property (
      st_q == ST_FWD_STB && fifo_q ##1 st_q == ST_FWD_REL);

   COV_REVERSAL: cover property (
      st_q == ST_FWD_IDLE ##1 st_q == ST_REV_IDLE);

   COV_REV_DONE: cover property (rx_valid_q);

endmodule // ecpph_top

// file: dv/ecpph_periph_model.sv
// peripheral model on the far side of the parallel cable
`timescale 1ns/100ps
module ecpph_periph_model (
   input wire logic clk,
   input wire logic host_clk,
   input wire logic host_ack,
   input wire ecpph_pkg::ecpph_data_t pd_in,
   input wire logic stall,
   input wire logic rev_req,
   input wire logic [3:0] dly,
   output logic busy,
   output logic ack_n,
   output logic fault_n,
   output ecpph_pkg::ecpph_data_t pd_out,
   output logic got_v,
   output ecpph_pkg::ecpph_data_t got_d
);
   import ecpph_pkg::*;
   // ------
   // handshakes
   // ------
   assign fault_n = ~rev_req;
   initial begin
      busy = 1'b0;
      ack_n = 1'b1;
      pd_out = 8'h00;
      got_v = 1'b0;
      got_d = 8'h00;
   end
   always begin
      @(negedge clk);
      got_v = 1'b0;
      if (stall) begin
         busy = 1'b1;
      end else if (!host_clk) begin
         repeat (dly) @(negedge clk);
         got_d = pd_in;
         busy = 1'b1;
         while (!host_clk) @(negedge clk);
         repeat (dly) @(negedge clk);
         busy = 1'b0;
         got_v = 1'b1;
      end else begin
         busy = 1'b0;
      end
   end
   task automatic send(input ecpph_data_t b);
      int n;
      n = 0;
      @(negedge clk);
      while (host_ack && n < 200) begin
         @(negedge clk);
         n++;
      end
      pd_out = b;
      repeat (6) @(negedge clk);
      ack_n = 1'b0;
      while (!host_ack && n < 400) begin
         @(negedge clk);
         n++;
      end
      ack_n = 1'b1;
      repeat (dly) @(negedge clk);
      pd_out = ~b;
   endtask
endmodule // ecpph_periph_model

// file: dv/tb_top.sv
// self-checking bench for the parallel handshake block
`timescale 1ns/100ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin \
   fail_count++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb_top;
   import ecpph_pkg::*;
   // ------
   // signals
   // ------
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ecp = 1'b1;
   logic fifo = 1'b0;
   logic epp = 1'b0;
   logic epp_wr = 1'b0;
   logic rev_en = 1'b0;
   logic fwd_req = 1'b0;
   logic tx_valid = 1'b0;
   ecpph_data_t tx_data = 8'h00;
   logic rx_ready = 1'b1;
   logic wait_n = 1'b1;
   logic nack_hold = 1'b0;
   logic stall = 1'b0;
   logic rev_req = 1'b0;
   logic [3:0] dly = 4'h1;
   logic tx_ready, rx_valid, pd_oe, hc_o, hc_oe, ha_o, ha_oe;
   logic wait_set, write_n, rev, busy, ack_n, fault_n, got_v;
   logic hc_w, ha_w;
   ecpph_data_t rx_data, pd_o, pd_p, got_d, ef, er, b;
   ecpph_data_t exp_fwd[$];
   ecpph_data_t exp_rx[$];
   int fail_count = 0;
   int checks_done = 0;
   int seed = 43616;
   int i;
   int n;
   realtime t_pd = 0;
   realtime t_lo = 0;
   assign hc_w = hc_oe ? hc_o : 1'b1;
   assign ha_w = ha_oe ? ha_o : 1'b1;
   always #12.5 clk = ~clk;
   ecpph_top dut (
      .clk(clk), .reset(reset), .ecp_mode_i(ecp), .fifo_mode_i(fifo),
      .epp_mode_i(epp), .epp_wr_i(epp_wr), .rev_en_i(rev_en),
      .fwd_req_i(fwd_req), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
      .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
      .rx_ready_i(rx_ready), .pd_i(pd_oe ? pd_o : pd_p), .pd_o(pd_o),
      .pd_oe(pd_oe), .host_clk_o(hc_o), .host_clk_oe(hc_oe),
      .host_ack_o(ha_o), .host_ack_oe(ha_oe), .periph_ack_i(busy),
      .periph_clk_i(ack_n & ~nack_hold), .periph_req_n_i(fault_n),
      .wait_n_i(wait_n), .wait_n_settled_o(wait_set),
      .write_n_o(write_n), .rev_o(rev)
   );
   ecpph_periph_model pm (
      .clk(clk), .host_clk(hc_w), .host_ack(ha_w), .pd_in(pd_o),
      .stall(stall), .rev_req(rev_req), .dly(dly), .busy(busy),
      .ack_n(ack_n), .fault_n(fault_n), .pd_out(pd_p), .got_v(got_v),
      .got_d(got_d)
   );
   // ------
   // watchers
   // ------
   always @(posedge clk) begin
      if (got_v) begin
         ef = exp_fwd.size() ? exp_fwd.pop_front() : ~got_d;
         `CHK(got_d, ef, "forward byte")
      end
      if (rx_valid) begin
         er = exp_rx.size() ? exp_rx.pop_front() : ~rx_data;
         `CHK(rx_data, er, "reverse byte")
      end
   end
   always @(pd_o or pd_oe) t_pd = $realtime;
   always @(negedge hc_w) if (!reset) begin
      `CHK(($realtime - t_pd) >= SETUP_NS, 1'b1, "data setup")
      `CHK(hc_oe, 1'b1, "strobe driven")
      t_lo = $realtime;
   end
   always @(posedge hc_w) if (!reset) begin
      #1;
      if (fifo)
         `CHK(int'($realtime - t_lo) - 1, FIFO_STB_NS, "strobe width")
      `CHK(hc_oe, ecp, "release drive")
   end
   // ------
   // tasks
   // ------
   task automatic push(input ecpph_data_t d);
      int k;
      k = 0;
      dly = 4'($unsigned($random(seed)) % 5);
      tx_data = d;
      tx_valid = 1'b1;
      @(posedge clk);
      while (!tx_ready && k < 2000) begin
         @(posedge clk);
         k++;
      end
      exp_fwd.push_back(d);
      @(negedge clk);
   endtask
   task automatic drain();
      n = 0;
      while ((exp_fwd.size() != 0 || busy || !hc_w) && n < 4000) begin
         @(negedge clk);
         n++;
      end
      repeat (6) @(negedge clk);
      `CHK(exp_fwd.size(), 0, "all sent")
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #750000;
      `CHK(1'b0, 1'b1, "watchdog expired")
      report_and_stop();
   end
   // ------
   // scenarios
   // ------
   initial begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(hc_w, HOST_CLK_IDLE, "strobe idle")
      `CHK(pd_oe, 1'b0, "data released")
      `CHK(rev, 1'b1, "direction at reset")
      `CHK(tx_ready, 1'b1, "fifo ready")
      `CHK(write_n, WRITE_N_IDLE, "write idle")
      `CHK(wait_set, 1'b1, "wait idle")
      $display("test reset done");
      stall = 1'b1;
      rev_req = 1'b1;
      repeat (4) @(negedge clk);
      for (i = 0; i < FIFO_DEPTH; i++) push(8'($random(seed)));
      rev_req = 1'b0;
      tx_data = 8'hA5;
      repeat (4) @(negedge clk);
      `CHK(tx_ready, 1'b0, "fifo full")
      `CHK(hc_w, 1'b1, "no strobe while busy")
      tx_valid = 1'b0;
      stall = 1'b0;
      drain();
      $display("test ecp forward done");
      rev_en = 1'b1;
      n = 0;
      while (!(rev && !pd_oe && !ha_w) && n < 50) begin
         @(negedge clk);
         n++;
      end
      `CHK(pd_oe, 1'b0, "reversed on pending request")
      `CHK(ha_w, HOST_ACK_REV, "reverse idle")
      for (i = 0; i < 4; i++) begin
         b = 8'($random(seed));
         exp_rx.push_back(b);
         rx_ready = (i != 2);
         fork
            pm.send(b);
            if (i == 2) begin
               repeat (20) @(negedge clk);
               `CHK(ha_w, 1'b0, "held off")
               rx_ready = 1'b1;
            end
         join
      end
      repeat (8) @(negedge clk);
      `CHK(exp_rx.size(), 0, "all received")
      fwd_req = 1'b1;
      rev_en = 1'b0;
      n = 0;
      while (ha_w !== HOST_ACK_FWD && n < 50) begin
         @(negedge clk);
         n++;
      end
      `CHK(ha_w, HOST_ACK_FWD, "back to forward")
      fwd_req = 1'b0;
      $display("test reverse done");
      ecp = 1'b0;
      fifo = 1'b1;
      nack_hold = 1'b1;
      for (i = 0; i < 3; i++) push(8'($random(seed)));
      tx_valid = 1'b0;
      drain();
      nack_hold = 1'b0;
      fifo = 1'b0;
      ecp = 1'b1;
      $display("test fifo mode done");
      for (i = 0; i < 4; i++) begin
         {epp, epp_wr} = 2'(i);
         @(negedge clk);
         `CHK(write_n, ~(epp & epp_wr), "write level")
      end
      {epp, epp_wr} = 2'b00;
      wait_n = 1'b0;
      @(negedge clk);
      wait_n = 1'b1;
      n = 0;
      repeat (8) begin
         @(negedge clk);
         n += (wait_set !== 1'b1);
      end
      `CHK(n, 0, "glitch filtered")
      wait_n = 1'b0;
      n = 0;
      while (wait_set !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      `CHK(n >= SETTLE_CYC && n <= 8, 1'b1, "settled low")
      $display("test epp done");
      report_and_stop();
   end
endmodule // tb_top
